// [src/beam_pattern_measurement.sv]
// Beam pattern measurement top: APB registers, blanking verdict,
// display timer, signal pin and process data.
// Assumes beam, sync, key and IO-Link status pins are asynchronous.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module beam_pattern_measurement #(
    parameter int NB       = bpm_pkg::BPM_BEAMS,
    parameter int DISP_CYC = bpm_pkg::BPM_DISP_CYC
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Receiver pins
    input  wire logic [NB-1:0]         beamPin,
    input  wire logic                  syncPin,
    input  wire logic                  keyPin,
    input  wire logic                  ioLinkActive,
    // Outputs
    output logic                       safetySwitchOutput,
    output logic                       ledSafetyOn,
    output logic                       ledError,
    output logic                       segDisplayOn,
    output logic                       ioPinOut,
    output logic                       ioPinOe,
    output bpm_pkg::bpm_meas_t         processData,
    output logic                       processDataValid,
    output logic                       irq
);
    import bpm_pkg::*;

    initial begin
        if (NB < 2 || NB > 32) $error("beam_pattern_measurement: NB out of range");
        if (DISP_CYC < 1) $error("beam_pattern_measurement: DISP_CYC too small");
    end

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int SW = NB + 3;

    logic [SW-1:0] syncA;
    logic [SW-1:0] syncB;
    logic [NB-1:0] beamS;
    logic          syncS;
    logic          keyS;
    logic          iolS;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            syncA <= '0;
            syncB <= '0;
        end else begin
            syncA <= {ioLinkActive, keyPin, syncPin, beamPin};
            syncB <= syncA;
        end
    end

    assign beamS = syncB[NB-1:0];
    assign syncS = syncB[NB];
    assign keyS  = syncB[NB+1];
    assign iolS  = syncB[NB+2];

    // ****************************************
    // Registers
    // ****************************************
    logic [BPM_CTRL_W-1:0] ctrl_reg;
    logic [31:0]           mask_reg;
    logic [7:0]            redLim_reg;
    logic [BPM_IRQ_W-1:0]  irqSt_reg;
    logic [BPM_IRQ_W-1:0]  irqMsk_reg;
    logic [BPM_IRQ_W-1:0]  irqEv;
    logic                  wrEn;
    logic                  rdSetup;
    logic                  ackWr;
    bpm_mode_t             mode;
    logic                  energy;
    bpm_sig_t              sigSel;
    logic [7:0]            teach;
    bpm_meas_t             measReg;
    logic                  errLatch;
    logic [31:0]           rdMux;
    logic                  hit;

    assign wrEn    = psel && penable && pwrite && pready;
    assign rdSetup = psel && !penable;
    assign ackWr   = wrEn && paddr == BPM_OFS_CTRL && pwdata[BPM_CTRL_ACK];
    assign mode    = bpm_mode_t'(ctrl_reg[BPM_CTRL_MODE +: 3]);
    assign energy  = ctrl_reg[BPM_CTRL_ENRG];
    assign sigSel  = bpm_sig_t'(ctrl_reg[BPM_CTRL_SIGF +: 2]);
    assign teach   = {6'h00, ctrl_reg[BPM_CTRL_TEACH +: 2]};

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg   <= BPM_CTRL_RST;
            mask_reg   <= BPM_MASK_RST;
            redLim_reg <= BPM_REDLIM_RST;
            irqMsk_reg <= '0;
        end else if (wrEn) begin
            case (paddr)
                BPM_OFS_CTRL:   ctrl_reg   <= pwdata[BPM_CTRL_W-1:0];
                BPM_OFS_MASK:   mask_reg   <= pwdata;
                BPM_OFS_REDLIM: redLim_reg <= pwdata[7:0];
                BPM_OFS_IRQMSK: irqMsk_reg <= pwdata[BPM_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Sticky status, set wins over write-one clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irqSt_reg <= '0;
        end else if (wrEn && paddr == BPM_OFS_IRQST) begin
            irqSt_reg <= (irqSt_reg & ~pwdata[BPM_IRQ_W-1:0]) | irqEv;
        end else begin
            irqSt_reg <= irqSt_reg | irqEv;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqSt_reg & irqMsk_reg);
        end
    end

    always_comb begin
        rdMux = 32'h0000_0000;
        hit   = 1'b1;
        case (paddr)
            BPM_OFS_CTRL:   rdMux = {24'h000000, ctrl_reg & ~(8'(1) << BPM_CTRL_ACK)};
            BPM_OFS_MASK:   rdMux = mask_reg;
            BPM_OFS_MEAS0:  rdMux = {measReg.first, measReg.last, measReg.count, measReg.largest};
            BPM_OFS_MEAS1:  rdMux = {20'h00000, iolS, errLatch, safetySwitchOutput, syncS, 8'h00}
                                    | {24'h000000, measReg.objects};
            BPM_OFS_IRQST:  rdMux = {28'h0000000, irqSt_reg};
            BPM_OFS_IRQMSK: rdMux = {28'h0000000, irqMsk_reg};
            BPM_OFS_REDLIM: rdMux = {24'h000000, redLim_reg};
            default:        hit   = 1'b0;
        endcase
    end

    // Zero wait state answer prepared in setup cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= rdSetup;
            pslverr <= rdSetup && !hit;
            prdata  <= (rdSetup && !pwrite) ? rdMux : 32'h0000_0000;
        end
    end

    // ****************************************
    // Measurement
    // ****************************************
    bpm_meas_t scanMeas;
    logic      scanDone;
    logic      scanStart;

    assign scanStart = 1'b1;

    bpm_scan #(
        .NB (NB)
    ) u_scan (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .start   (scanStart),
        .beams   (beamS),
        .meas    (scanMeas),
        .done    (scanDone)
    );

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            measReg <= {5{BPM_NOSYNC}};
        end else if (!syncS) begin
            measReg <= {5{BPM_NOSYNC}};
        end else if (scanDone) begin
            measReg <= scanMeas;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            processData      <= {5{BPM_NOSYNC}};
            processDataValid <= 1'b0;
        end else begin
            processData      <= measReg;
            processDataValid <= iolS && scanDone;
        end
    end

    // ****************************************
    // Blanking verdict
    // ****************************************
    logic [NB-1:0] mask;
    logic [NB-1:0] dil;
    logic [NB-1:0] ero;
    logic          pen;
    logic          errNow;

    assign mask = mask_reg[NB-1:0];
    assign dil  = mask | (mask << BPM_EDGE_SHIFT) | (mask >> BPM_EDGE_SHIFT);
    assign ero  = mask & (mask << BPM_EDGE_SHIFT) & (mask >> BPM_EDGE_SHIFT);

    always_comb begin
        pen    = 1'b0;
        errNow = 1'b0;
        case (mode)
            MODE_NONE: pen = |beamS;
            MODE_FIX: begin
                pen    = |(beamS & ~mask);
                errNow = |(mask & ~beamS);
            end
            MODE_EDGE: begin
                pen    = |(beamS & ~dil);
                errNow = |(ero & ~beamS);
            end
            MODE_FLOAT: begin
                errNow = measReg.objects != teach || measReg.objects > BPM_FLOAT_MAX;
            end
            MODE_REDUCED: pen = measReg.largest > redLim_reg;
            default: pen = 1'b1;
        endcase
        if (!syncS) begin
            errNow = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            errLatch <= 1'b0;
        end else if (errNow) begin
            errLatch <= 1'b1;
        end else if (ackWr) begin
            errLatch <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            safetySwitchOutput <= 1'b0;
        end else begin
            safetySwitchOutput <= syncS && !pen && !errLatch && !errNow;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ledSafetyOn <= 1'b0;
            ledError    <= 1'b0;
        end else begin
            ledSafetyOn <= safetySwitchOutput;
            ledError    <= errLatch;
        end
    end

    // ****************************************
    // Segment display
    // ****************************************
    logic [31:0] dispCnt;
    logic        keyOld;
    logic [1:0]  statOld;
    logic        dispTrig;
    logic        dispEnd;

    assign dispTrig = (keyS && !keyOld) || statOld != {safetySwitchOutput, errLatch};
    assign dispEnd  = energy && !dispTrig && dispCnt == 32'h0000_0001;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dispCnt      <= 32'h0000_0000;
            keyOld       <= 1'b0;
            statOld      <= 2'b00;
            segDisplayOn <= 1'b1;
        end else begin
            keyOld  <= keyS;
            statOld <= {safetySwitchOutput, errLatch};
            if (!energy) begin
                dispCnt      <= 32'h0000_0000;
                segDisplayOn <= 1'b1;
            end else if (dispTrig) begin
                dispCnt      <= 32'(DISP_CYC);
                segDisplayOn <= 1'b1;
            end else if (dispCnt != 32'h0000_0000) begin
                dispCnt      <= dispCnt - 32'h0000_0001;
                segDisplayOn <= dispCnt != 32'h0000_0001;
            end else begin
                segDisplayOn <= 1'b0;
            end
        end
    end

    // ****************************************
    // Signal pin and events
    // ****************************************
    // switching output without IO-Link
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ioPinOut <= 1'b0;
            ioPinOe  <= 1'b0;
        end else begin
            ioPinOe <= !iolS;
            case (sigSel)
                SIG_SAFETY: ioPinOut <= !iolS && safetySwitchOutput;
                SIG_SYNC: ioPinOut <= !iolS && syncS;
                SIG_ERR:  ioPinOut <= !iolS && errLatch;
                default:  ioPinOut <= 1'b0;
            endcase
        end
    end

    logic safetyOld;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            safetyOld <= 1'b0;
        end else begin
            safetyOld <= safetySwitchOutput;
        end
    end

    always_comb begin
        irqEv               = '0;
        irqEv[BPM_IRQ_MEAS] = scanDone;
        irqEv[BPM_IRQ_OFF]  = safetyOld && !safetySwitchOutput;
        irqEv[BPM_IRQ_ERR]  = errNow && !errLatch;
        irqEv[BPM_IRQ_DISP] = dispEnd;
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence seqErr;
        errNow;
    endsequence

    sequence seqOffHeld;
        !safetySwitchOutput ##1 errLatch;
    endsequence

    AST_NOSYNC_255: assert property (!syncS |=> measReg == {5{BPM_NOSYNC}}) else $error("no sync but not 255");
    AST_ERR_OFF: assert property (seqErr |=> seqOffHeld) else $error("error did not switch off");
    AST_RED_NOERR: assert property (mode == MODE_REDUCED && !errLatch && !ackWr |=> !errLatch) else $error("reduced raised error");
    AST_FLOAT_MAX: assert property (syncS && mode == MODE_FLOAT && measReg.objects > BPM_FLOAT_MAX |=> !safetySwitchOutput) else $error("too many floating objects");
    AST_FIX_PEN: assert property (syncS && mode == MODE_FIX && |(beamS & ~mask) |=> !safetySwitchOutput) else $error("fix blanking missed penetration");
    AST_DISP_STD: assert property (!energy |=> segDisplayOn) else $error("standard display off");
    AST_LED: assert property (##1 ledSafetyOn == $past(safetySwitchOutput)) else $error("LED not following");
    AST_IOPIN: assert property (!iolS |=> ioPinOe) else $error("pin not driven");
    AST_PDATA: assert property (iolS && scanDone |=> processDataValid ##0 processData == $past(measReg)) else $error("process data missing");

endmodule

// [src/bpm_pkg.sv]
// Constants, types and register map of the beam pattern measurement block.
// Assumes one 25 MHz system clock and an APB master with 32-bit data.
//
// Contract
// - First interrupted index, zero when field clear
// - Last interrupted index, zero when field clear
// - Count all interrupted beams over every object
// - Report beam count of the largest object
// - Report number of separate objects
// - All measurements read 255 without synchronisation
// - Tolerated objects still count in measurements
// - Movement allowed depends on blanking mode
// - Floating blanking monitors objects, at most three
// - Blanked object leaving: outputs off, except reduced
// - Blanked beams clearing: outputs off, except reduced
// - Energy mode display on by event, 30 s
// - Status LEDs always follow device state
// - Without IO-Link, pin is switching output
// - Measurements offered as cyclic process data
package bpm_pkg;

    // ****************************************
    // Sizes and timing
    // ****************************************
    localparam int          BPM_BEAMS      = 32;
    localparam int          BPM_MEAS_W     = 8;
    localparam logic [7:0]  BPM_NOSYNC     = 8'hFF;
    localparam logic [7:0]  BPM_FLOAT_MAX  = 8'h03;
    localparam int          BPM_EDGE_SHIFT = 1;
    localparam int          BPM_CLK_HZ     = 25_000_000;
    localparam int          BPM_DISP_S     = 30;
    localparam int          BPM_DISP_CYC   = BPM_DISP_S * BPM_CLK_HZ;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0]  BPM_OFS_CTRL   = 8'h00;
    localparam logic [7:0]  BPM_OFS_MASK   = 8'h04;
    localparam logic [7:0]  BPM_OFS_MEAS0  = 8'h08;
    localparam logic [7:0]  BPM_OFS_MEAS1  = 8'h0C;
    localparam logic [7:0]  BPM_OFS_IRQST  = 8'h10;
    localparam logic [7:0]  BPM_OFS_IRQMSK = 8'h14;
    localparam logic [7:0]  BPM_OFS_REDLIM = 8'h18;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int          BPM_CTRL_MODE  = 0;
    localparam int          BPM_CTRL_ENRG  = 3;
    localparam int          BPM_CTRL_SIGF  = 4;
    localparam int          BPM_CTRL_TEACH = 6;
    localparam int          BPM_CTRL_ACK   = 8;
    localparam int          BPM_CTRL_W     = 8;
    localparam logic [7:0]  BPM_CTRL_RST   = 8'h00;
    localparam logic [31:0] BPM_MASK_RST   = 32'h0000_0000;
    localparam logic [7:0]  BPM_REDLIM_RST = 8'h02;
    localparam int          BPM_IRQ_MEAS   = 0;
    localparam int          BPM_IRQ_OFF    = 1;
    localparam int          BPM_IRQ_ERR    = 2;
    localparam int          BPM_IRQ_DISP   = 3;
    localparam int          BPM_IRQ_W      = 4;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {MODE_NONE, MODE_FIX, MODE_EDGE, MODE_FLOAT, MODE_REDUCED} bpm_mode_t;
    typedef enum logic [1:0] {SIG_SAFETY, SIG_SYNC, SIG_OFF, SIG_ERR} bpm_sig_t;
    typedef enum logic [1:0] {SC_IDLE, SC_RUN, SC_DONE} bpm_scan_st_t;

    typedef struct packed {
        logic [7:0] first;
        logic [7:0] last;
        logic [7:0] count;
        logic [7:0] largest;
        logic [7:0] objects;
    } bpm_meas_t;

endpackage

// [src/bpm_scan.sv]
// Serial scanner deriving measurements from one beam snapshot.
// Assumes beams arrive already synchronised to clk_sys.
`timescale 1ns/100ps
module bpm_scan #(
    parameter int NB = bpm_pkg::BPM_BEAMS
) (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               resetn,
    // Control
    input  wire logic               start,
    input  wire logic [NB-1:0]      beams,
    // Result
    output bpm_pkg::bpm_meas_t      meas,
    output logic                    done
);
    import bpm_pkg::*;

    localparam int IW = $clog2(NB);

    initial begin
        if (NB < 2 || NB > 254) $error("bpm_scan: NB out of range");
    end

    bpm_scan_st_t   state;
    logic [NB-1:0]  snap;
    logic [IW-1:0]  idx;
    logic           prev;
    logic [7:0]     run;
    bpm_meas_t      acc;
    logic [7:0]     pos;
    logic           bit0;

    assign pos  = 8'(idx) + 8'h01;
    assign bit0 = snap[idx];

    // ****************************************
    // Scan walk
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= SC_IDLE;
            snap  <= '0;
            idx   <= '0;
            prev  <= 1'b0;
            run   <= 8'h00;
            acc   <= '0;
            meas  <= '0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                SC_IDLE: begin
                    if (start) begin
                        snap  <= beams;
                        idx   <= '0;
                        prev  <= 1'b0;
                        run   <= 8'h00;
                        acc   <= '0;
                        state <= SC_RUN;
                    end
                end
                SC_RUN: begin
                    prev <= bit0;
                    if (bit0) begin
                        acc.count <= acc.count + 8'h01;
                        acc.last  <= pos;
                        if (acc.first == 8'h00) begin
                            acc.first <= pos;
                        end
                        run <= run + 8'h01;
                        if (run + 8'h01 > acc.largest) begin
                            acc.largest <= run + 8'h01;
                        end
                        if (!prev) begin
                            acc.objects <= acc.objects + 8'h01;
                        end
                    end else begin
                        run <= 8'h00;
                    end
                    if (idx == IW'(NB - 1)) begin
                        state <= SC_DONE;
                    end else begin
                        idx <= idx + 1'b1;
                    end
                end
                SC_DONE: begin
                    meas  <= acc;
                    done  <= 1'b1;
                    state <= SC_IDLE;
                end
                default: state <= SC_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    AST_FREE_ZERO: assert property (done && meas.count == 8'h00 |-> meas.first == 8'h00 && meas.last == 8'h00) else $error("clear field index not zero");
    AST_SPAN: assert property (done && meas.count != 8'h00 |-> meas.first <= meas.last && meas.count <= meas.last - meas.first + 8'h01) else $error("count exceeds span");
    AST_LARGEST: assert property (done |-> meas.largest <= meas.count && (meas.objects == 8'h00) == (meas.count == 8'h00)) else $error("largest or objects inconsistent");
    AST_PERIOD: assert property (start && state == SC_IDLE |-> ##(NB + 2) done) else $error("scan took wrong time");

endmodule

// [dv/bpm_iol_master.sv]
// IO-Link master model reading cyclic process data.
// Assumes processDataValid is a one-cycle pulse on clk_sys.
`timescale 1ns/100ps
module bpm_iol_master (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               resetn,
    // Bench control
    input  wire logic               linkUp,
    // Device side
    input  wire bpm_pkg::bpm_meas_t processData,
    input  wire logic               processDataValid,
    output logic                    ioLinkActive,
    // Captured frame
    output bpm_pkg::bpm_meas_t      capData,
    output logic                    capValid
);
    import bpm_pkg::*;
    // ****************************************
    // Link state and frame capture
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ioLinkActive <= 1'b0;
            capData      <= '0;
            capValid     <= 1'b0;
        end else begin
            ioLinkActive <= linkUp;
            capValid     <= processDataValid & ioLinkActive;
            if (processDataValid)
                capData <= processData;
        end
    end
endmodule

// [dv/testbench.sv]
// Self-checking bench: APB master, beam stimulus, IO-Link master model.
// Assumes an APB slave that raises pready in its own time.
`timescale 1ns/100ps
module testbench;
    import bpm_pkg::*;
    localparam int NB = 16;
    localparam logic [47:0] TBL [13] = '{
        48'h0000_0000_0000, 48'h0000_0000_0010, 48'h0001_00F0_00F0,
        48'h0001_00F0_0070, 48'h0001_00F0_01F0, 48'h0002_00F0_01E0,
        48'h0002_00F0_03C0, 48'h0043_0000_0300, 48'h0043_0000_3030,
        48'h0043_0000_0000, 48'h0004_0000_0006, 48'h0004_0000_000E,
        48'h0004_0000_0000};
    localparam logic [12:0] EXPV = 13'b1010010100101;
    localparam logic [12:0] EXPE = 13'b0001101001000;
    logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, syncPin, keyPin;
    logic linkUp, ioLinkActive, capValid, irq, pdValid;
    logic safetySwitchOutput, ledSafetyOn, ledError, segDisplayOn, ioPinOut, ioPinOe;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rdat;
    logic [NB-1:0] beamPin;
    logic          rerr;
    bpm_meas_t     processData, capData;
    bpm_meas_t     expQ[$];
    int            nErrors, samplesChecked, cycles;
    int            seed = 32'h3406;
    beam_pattern_measurement #(.NB(NB), .DISP_CYC(50)) i_beam_pattern_measurement (
        .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .beamPin(beamPin), .syncPin(syncPin),
        .keyPin(keyPin), .ioLinkActive(ioLinkActive),
        .safetySwitchOutput(safetySwitchOutput), .ledSafetyOn(ledSafetyOn),
        .ledError(ledError), .segDisplayOn(segDisplayOn), .ioPinOut(ioPinOut),
        .ioPinOe(ioPinOe), .processData(processData), .processDataValid(pdValid),
        .irq(irq));
    bpm_iol_master i_bpm_iol_master (
        .clk_sys(clk_sys), .resetn(resetn), .linkUp(linkUp),
        .processData(processData), .processDataValid(pdValid),
        .ioLinkActive(ioLinkActive), .capData(capData), .capValid(capValid));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic bpm_meas_t mf(input logic [NB-1:0] b);
        bpm_meas_t m;
        int        run;
        m = '0;
        run = 0;
        for (int i = 0; i < NB; i++) begin
            if (b[i]) begin
                if (m.first == 8'h00) m.first = 8'(i + 1);
                m.last = 8'(i + 1);
                m.count++;
                run++;
                if (run == 1) m.objects++;
                if (run > m.largest) m.largest = 8'(run);
            end else run = 0;
        end
        return m;
    endfunction
    task report_and_stop;
        $display("checks %0d mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ****************************************
    // Clock, watcher and timeout
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (capValid === 1'b1 && expQ.size() > 0) chk(capData, expQ.pop_front());
        if (cycles == 20000) begin
            nErrors++;
            report_and_stop();
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata, keyPin} = '0;
        beamPin = '0;
        syncPin = 1'b1;
        linkUp = 1'b1;
        cyc(2);
        chk(processData, 40'hFF_FFFF_FFFF);
        chk(segDisplayOn, 1'b1);
        resetn <= 1'b1;
        apb(0, BPM_OFS_REDLIM, 0);
        chk(rdat, 32'(BPM_REDLIM_RST));
        apb(0, BPM_OFS_CTRL, 0);
        chk(rdat, 32'h0000_0000);
        apb(0, 8'h1C, 0);
        chk({rerr, rdat}, 33'h1_0000_0000);
        $display("test reset done");
        for (int i = 0; i < 13; i++) begin
            beamPin <= TBL[i][15:0];
            apb(1, BPM_OFS_MASK, 32'(TBL[i][31:16]));
            apb(1, BPM_OFS_CTRL, 32'(TBL[i][47:32]));
            cyc(60);
            apb(1, BPM_OFS_CTRL, 32'(TBL[i][47:32]) | 32'h0000_0100);
            cyc(60);
            chk(safetySwitchOutput, EXPV[i]);
            chk(ledSafetyOn, EXPV[i]);
            chk(ledError, EXPE[i]);
        end
        $display("test verdict done");
        apb(1, BPM_OFS_CTRL, 0);
        for (int i = 0; i < 8; i++) begin
            beamPin <= (i == 0) ? '0 : NB'($random(seed)) & NB'($random(seed));
            syncPin <= (i != 7);
            cyc(60);
            if (i == 7) expQ.push_back(40'hFF_FFFF_FFFF);
            else expQ.push_back(mf(beamPin));
            for (int k = 0; k < 200 && expQ.size() > 0; k++) cyc(1);
            chk(expQ.size(), 0);
        end
        apb(0, BPM_OFS_MEAS0, 0);
        chk(rdat, 32'hFFFF_FFFF);
        $display("test measure done");
        beamPin <= '0;
        syncPin <= 1'b1;
        linkUp <= 1'b0;
        cyc(60);
        for (int f = 0; f < 4; f++) begin
            apb(1, BPM_OFS_CTRL, 32'(f << 4));
            cyc(5);
            chk({ioPinOe, ioPinOut}, {1'b1, f < 2});
        end
        linkUp <= 1'b1;
        cyc(5);
        chk(ioPinOe, 1'b0);
        $display("test pin done");
        apb(1, BPM_OFS_IRQMSK, 32'h0000_0002);
        apb(1, BPM_OFS_IRQST, 32'h0000_000F);
        beamPin <= 16'h0001;
        cyc(10);
        chk(irq, 1'b1);
        apb(1, BPM_OFS_IRQST, 32'h0000_0002);
        cyc(3);
        chk(irq, 1'b0);
        $display("test irq done");
        apb(1, BPM_OFS_CTRL, 32'h0000_0008);
        cyc(70);
        chk(segDisplayOn, 1'b0);
        keyPin <= 1'b1;
        cyc(4);
        keyPin <= 1'b0;
        cyc(4);
        chk(segDisplayOn, 1'b1);
        cyc(70);
        chk(segDisplayOn, 1'b0);
        apb(1, BPM_OFS_CTRL, 0);
        cyc(4);
        chk(segDisplayOn, 1'b1);
        $display("test display done");
        report_and_stop();
    end
endmodule
